//--- verilog/tfqs_frame_sequencer.sv
// Operation
// - Frame is sub-frames then frame dead time.
// - Each sub-frame runs quads in order.
// - Each quad applies its own phase offset.
// - Quad stages: reset, integration, readout, dead.
// - Reset stage drives sensor reset.
// - Integration enables modulation of pixels, illumination.
// - Readout transfers only region-of-interest data.
// - Dead time: sensor inactive, converter low power.
// - System clock rate equals input clock rate.
// - Reset stage lasts 720 system clocks.
// - Dead time spread across quads unless lumped.
`timescale 1ns/1ps
`default_nettype none
module tfqs_frame_sequencer
#(
    parameter int unsigned QUADS = tfqs_pkg::TFQS_QUADS // Quads per sub-frame.
)
(
    input  wire logic                                    CLOCK_I,         // System clock, the input clock itself.
    input  wire logic                                    RSTN_I,          // Asynchronous reset, active low.
    input  wire logic                                    ENABLE_I,        // Run the sequencer.
    input  wire logic                                    LUMPED_DEAD_I,   // Gather dead time at frame end.
    input  wire logic [tfqs_pkg::TFQS_SIDX_W-1:0]        SUBFRAMES_I,     // Sub-frames per frame.
    input  wire logic [tfqs_pkg::TFQS_CNT_W-1:0]         INTEG_CYC_I,     // Integration cycles per quad.
    input  wire logic [tfqs_pkg::TFQS_CNT_W-1:0]         READ_CYC_I,      // Readout cycles per quad.
    input  wire logic [tfqs_pkg::TFQS_CNT_W-1:0]         QDEAD_CYC_I,     // Dead cycles per quad.
    input  wire logic [QUADS*tfqs_pkg::TFQS_PHASE_W-1:0] PHASES_I,        // Phase offset per quad.
    output logic                                         SENSOR_RESET_O,  // Clears the pixel charge.
    output logic                                         MOD_EN_O,        // Modulates pixels and illumination.
    output logic [tfqs_pkg::TFQS_PHASE_W-1:0]            PHASE_O,         // Phase offset of current quad.
    output logic                                         READOUT_O,       // Move region-of-interest data out.
    output logic                                         SENSOR_ACTIVE_O, // Sensor powered for a stage.
    output logic                                         ADC_LOWPWR_O,    // Converter low-power mode.
    output logic [tfqs_pkg::TFQS_QIDX_W-1:0]             QUAD_O,          // Current quad index.
    output logic [tfqs_pkg::TFQS_SIDX_W-1:0]             SUBFRAME_O,      // Current sub-frame index.
    output logic                                         FRAME_START_O,   // Pulse at each frame start.
    output logic                                         FRAME_END_O      // Pulse at end of frame dead time.
);
    import tfqs_pkg::*;

    // The run and dead-time mode pins are synchronised before use, which adds two cycles of start latency.
    // The length, count and phase words are not synchronised: they are settings that must stay steady
    // from the moment enable is raised until the frame end pulse, or a stage may load a torn value.
    // The module runs straight on the 24 MHz input; no divider is used.

    // All sequencer state except the stage timer count in one record.
    typedef struct packed {
        tfqs_stage_e              stage;          // Current stage.
        logic [TFQS_QIDX_W-1:0]   quad;           // Quad within the sub-frame.
        logic [TFQS_SIDX_W-1:0]   sub;            // Sub-frame within the frame.
        logic [TFQS_PHASE_W-1:0]  phase;          // Phase presented to the modulation block.
        logic                     lumped;         // Dead-time mode latched per frame.
        logic                     fstart;         // Frame start pulse.
        logic                     fend;           // Frame end pulse.
        logic                     en_meta;        // Run pin, first synchroniser stage.
        logic                     en_sync;        // Run pin, second synchroniser stage.
        logic                     lump_meta;      // Dead-time mode pin, first synchroniser stage.
        logic                     lump_sync;      // Dead-time mode pin, second synchroniser stage.
    } tfqs_seq_s;

    tfqs_seq_s             st_ff;                 // Registered state.
    tfqs_seq_s             nxt_st;                // Next state.
    logic                  load;                  // Reload the stage timer.
    logic [TFQS_CNT_W-1:0] load_len;              // Length for the stage being entered.
    logic                  expire;                // Current stage is in its last cycle.
    logic [TFQS_CNT_W-1:0] fdead_len;             // Lumped frame dead time.
    logic [TFQS_CNT_W-1:0] reset_len;             // Reset stage length at counter width.

    assign reset_len = TFQS_CNT_W'(TFQS_RESET_CYC);

    // Lumped dead time is the per-quad dead time summed over the whole frame.
    // The product is cut to the counter width on purpose; a longer lumped gap wraps.
    assign fdead_len = TFQS_CNT_W'(QDEAD_CYC_I * QUADS * SUBFRAMES_I);

    // Picks the phase offset of one quad from the packed table.
    function automatic logic [TFQS_PHASE_W-1:0] quad_phase(input logic [TFQS_QIDX_W-1:0] q,
                                                         input logic [QUADS*TFQS_PHASE_W-1:0] tbl);
        quad_phase = tbl[q*TFQS_PHASE_W +: TFQS_PHASE_W];
    endfunction

    // Stage timer; every boundary below except leaving idle follows its expiry.
    tfqs_stage_timer u_timer (
        .CLOCK_I  (CLOCK_I),
        .RSTN_I   (RSTN_I),
        .load_i   (load),
        .len_i    (load_len),
        .expire_o (expire)
    );

    // Next-state logic walks stages, quads, sub-frames and frames.
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.fstart = 1'b0;
        nxt_st.fend   = 1'b0;
        load          = 1'b0;
        // Two flip-flops on each asynchronous pin; only the second stage feeds the logic.
        nxt_st.en_meta   = ENABLE_I;
        nxt_st.en_sync   = st_ff.en_meta;
        nxt_st.lump_meta = LUMPED_DEAD_I;
        nxt_st.lump_sync = st_ff.lump_meta;
        load_len      = reset_len;
        case (st_ff.stage)
            TFQS_IDLE:
            begin
                // A new frame starts at quad 0 of sub-frame 0.
                if (st_ff.en_sync)
                begin
                    nxt_st.stage  = TFQS_RST;
                    nxt_st.quad   = '0;
                    nxt_st.sub    = '0;
                    nxt_st.lumped = st_ff.lump_sync;
                    nxt_st.phase  = quad_phase('0, PHASES_I);
                    nxt_st.fstart = 1'b1;
                    load          = 1'b1;
                    load_len      = reset_len;
                end
            end
            TFQS_RST:
            begin
                if (expire)
                begin
                    nxt_st.stage = TFQS_INTEG;
                    load         = 1'b1;
                    load_len     = INTEG_CYC_I;
                end
            end
            TFQS_INTEG:
            begin
                if (expire)
                begin
                    nxt_st.stage = TFQS_READ;
                    load         = 1'b1;
                    load_len     = READ_CYC_I;
                end
            end
            TFQS_READ:
            begin
                if (expire)
                begin
                    // Lumped mode cuts the per-quad gap to one cycle and pays it at frame end.
                    nxt_st.stage = TFQS_QDEAD;
                    load         = 1'b1;
                    load_len     = st_ff.lumped ? TFQS_ZERO : QDEAD_CYC_I;
                end
            end
            TFQS_QDEAD:
            begin
                if (expire)
                begin
                    load = 1'b1;
                    if (32'(st_ff.quad) != QUADS - 1)
                    begin
                        // Next quad of the same sub-frame.
                        nxt_st.quad  = st_ff.quad + 1'b1;
                        nxt_st.phase = quad_phase(st_ff.quad + 1'b1, PHASES_I);
                        nxt_st.stage = TFQS_RST;
                        load_len     = reset_len;
                    end
                    else if (st_ff.sub + 1'b1 < SUBFRAMES_I)
                    begin
                        // Next sub-frame restarts at quad 0.
                        nxt_st.quad  = '0;
                        nxt_st.sub   = st_ff.sub + 1'b1;
                        nxt_st.phase = quad_phase('0, PHASES_I);
                        nxt_st.stage = TFQS_RST;
                        load_len     = reset_len;
                    end
                    else
                    begin
                        // Last sub-frame done: frame dead time closes the frame.
                        nxt_st.stage = TFQS_FDEAD;
                        load_len     = st_ff.lumped ? fdead_len : TFQS_ZERO;
                    end
                end
            end
            TFQS_FDEAD:
            begin
                if (expire)
                begin
                    // Stopping is only honoured between frames, so a frame is never cut short.
                    nxt_st.fend  = 1'b1;
                    nxt_st.stage = TFQS_IDLE;
                end
            end
            default:
            begin
                nxt_st.stage = TFQS_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st_ff <= '{stage: TFQS_IDLE, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Stage decodes drive the analog and datapath controls.
    // They come from the state register alone, so they move only just after a clock edge.
    assign SENSOR_RESET_O  = (st_ff.stage == TFQS_RST);
    assign MOD_EN_O        = (st_ff.stage == TFQS_INTEG);
    assign READOUT_O       = (st_ff.stage == TFQS_READ);
    assign SENSOR_ACTIVE_O = SENSOR_RESET_O | MOD_EN_O | READOUT_O;
    assign ADC_LOWPWR_O    = !READOUT_O;
    assign PHASE_O         = st_ff.phase;
    assign QUAD_O          = st_ff.quad;
    assign SUBFRAME_O      = st_ff.sub;
    assign FRAME_START_O   = st_ff.fstart;
    assign FRAME_END_O     = st_ff.fend;
endmodule
`default_nettype wire

//--- verilog/tfqs_pkg.sv
`default_nettype none
package tfqs_pkg;
    // Cycle counts are in system clock cycles; the system clock equals the input clock.
    localparam int unsigned TFQS_CNT_W       = 24;           // Width of every cycle-count field.
    localparam int unsigned TFQS_RESET_CYC   = 720;          // Length of the reset stage of each quad.
    localparam int unsigned TFQS_QUADS       = 4;            // Quads per sub-frame.
    localparam int unsigned TFQS_SUBFRAMES   = 16;           // Default sub-frames per frame.
    localparam int unsigned TFQS_PHASE_W     = 8;            // Width of one quad phase offset.
    localparam int unsigned TFQS_QIDX_W      = 2;            // Width of the quad index.
    localparam int unsigned TFQS_SIDX_W      = 8;            // Width of the sub-frame index.
    localparam logic [TFQS_CNT_W-1:0] TFQS_ONE = 24'h000001; // Unit step of a count.
    localparam logic [TFQS_CNT_W-1:0] TFQS_ZERO = 24'h000000; // Empty count.

    // Stages of the sequencer.
    typedef enum logic [2:0] {
        TFQS_IDLE   = 3'b000,
        TFQS_RST    = 3'b001,
        TFQS_INTEG  = 3'b010,
        TFQS_READ   = 3'b011,
        TFQS_QDEAD  = 3'b100,
        TFQS_FDEAD  = 3'b101
    } tfqs_stage_e;
endpackage
`default_nettype wire

//--- verilog/tfqs_stage_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down-counter that marks the last cycle of a stage.
module tfqs_stage_timer
(
    input  wire logic                            CLOCK_I,   // System clock.
    input  wire logic                            RSTN_I,    // Asynchronous reset, active low.
    input  wire logic                            load_i,    // Load a new stage length.
    input  wire logic [tfqs_pkg::TFQS_CNT_W-1:0] len_i,     // Stage length in cycles.
    output logic                                 expire_o   // High in the stage's last cycle.
);
    import tfqs_pkg::*;

    typedef struct packed {
        logic [TFQS_CNT_W-1:0] cnt;               // Cycles remaining, minus one.
    } tfqs_tmr_s;

    tfqs_tmr_s st_ff;                             // Registered state.
    tfqs_tmr_s nxt_st;                            // Next state.

    // A zero length is treated as one cycle so no stage can stall the chain.
    always_comb
    begin
        nxt_st = st_ff;
        if (load_i)
        begin
            nxt_st.cnt = (len_i == TFQS_ZERO) ? TFQS_ZERO : len_i - TFQS_ONE;
        end
        else if (st_ff.cnt != TFQS_ZERO)
        begin
            nxt_st.cnt = st_ff.cnt - TFQS_ONE;
        end
    end

    // State register.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Expiry looks at the register only; the parent decides its reload from it, so a load term here would loop.
    assign expire_o = (st_ff.cnt == TFQS_ZERO);
endmodule
`default_nettype wire

//--- tb/tfqs_props.sv
`timescale 1ns/1ps
`default_nettype none
// Watches stage order, reset stage length, indices and power outputs of the sequencer.
module tfqs_props
#(
    parameter int unsigned QUADS = tfqs_pkg::TFQS_QUADS // Quads per sub-frame.
)
(
    input wire logic                                    CLOCK_I,         // System clock.
    input wire logic                                    RSTN_I,          // Reset, active low.
    input wire logic [QUADS*tfqs_pkg::TFQS_PHASE_W-1:0] PHASES_I,        // Phase table.
    input wire logic                                    SENSOR_RESET_O,  // Reset stage.
    input wire logic                                    MOD_EN_O,        // Integration stage.
    input wire logic [tfqs_pkg::TFQS_PHASE_W-1:0]       PHASE_O,         // Current phase.
    input wire logic                                    READOUT_O,       // Readout stage.
    input wire logic                                    SENSOR_ACTIVE_O, // Sensor powered.
    input wire logic                                    ADC_LOWPWR_O,    // Converter asleep.
    input wire logic [tfqs_pkg::TFQS_QIDX_W-1:0]        QUAD_O,          // Quad index.
    input wire logic [tfqs_pkg::TFQS_SIDX_W-1:0]        SUBFRAME_O,      // Sub-frame index.
    input wire logic                                    FRAME_START_O    // Frame start pulse.
);
    import tfqs_pkg::*;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I);
    logic [11:0]            rst_run_ff; // Cycles spent in the current reset stage.
    logic [TFQS_QIDX_W-1:0] last_q_ff;  // Quad of the previous reset stage.
    logic [TFQS_SIDX_W-1:0] last_s_ff;  // Sub-frame of the previous reset stage.
    // The last-quad and last-sub-frame helpers change only in reset stages, so the quad order check sees the previous quad.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rst_run_ff <= 12'h000;
            last_q_ff  <= '0;
            last_s_ff  <= '0;
        end
        else
        begin
            rst_run_ff <= SENSOR_RESET_O ? rst_run_ff + 12'h001 : 12'h000;
            last_q_ff  <= SENSOR_RESET_O ? QUAD_O : last_q_ff;
            last_s_ff  <= SENSOR_RESET_O ? SUBFRAME_O : last_s_ff;
        end
    end
    sequence s_reset_done;
        $fell(SENSOR_RESET_O);
    endsequence
    sequence s_integ_done;
        $fell(MOD_EN_O);
    endsequence
    sequence s_quad_begin;
        $rose(SENSOR_RESET_O) && !FRAME_START_O;
    endsequence
    a_reset_len: assert property (s_reset_done |-> rst_run_ff == 12'(TFQS_RESET_CYC))
        else $error("reset stage length wrong");
    a_reset_then_integ: assert property (s_reset_done |-> MOD_EN_O && SENSOR_ACTIVE_O)
        else $error("integration does not follow reset");
    a_integ_then_read: assert property (s_integ_done |-> READOUT_O && !ADC_LOWPWR_O)
        else $error("readout does not follow integration");
    a_read_then_dead: assert property ($fell(READOUT_O) |-> !SENSOR_ACTIVE_O && ADC_LOWPWR_O)
        else $error("dead time does not follow readout");
    a_adc_sleep: assert property (ADC_LOWPWR_O != READOUT_O)
        else $error("converter power mode wrong");
    a_sensor_idle: assert property (SENSOR_ACTIVE_O == (SENSOR_RESET_O || MOD_EN_O || READOUT_O))
        else $error("sensor activity wrong");
    a_one_stage: assert property ($onehot0({SENSOR_RESET_O, MOD_EN_O, READOUT_O}))
        else $error("two stages at once");
    a_frame_start: assert property (FRAME_START_O |->
        SENSOR_RESET_O && QUAD_O == '0 && SUBFRAME_O == '0 ##1 !FRAME_START_O)
        else $error("frame start wrong");
    a_quad_phase: assert property (SENSOR_RESET_O |->
        PHASE_O == PHASES_I[QUAD_O*TFQS_PHASE_W +: TFQS_PHASE_W])
        else $error("quad phase wrong");
    a_quad_order: assert property (s_quad_begin |->
        (QUAD_O == last_q_ff + 2'h1 && SUBFRAME_O == last_s_ff) ||
        (QUAD_O == 2'h0 && SUBFRAME_O == last_s_ff + 8'h01))
        else $error("quad order wrong");
endmodule
`default_nettype wire

//--- tb/tfqs_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pixel array and converter: measures how long each quad modulates and reads out.
module tfqs_partner_model
(
    input  wire logic        clk_i,       // System clock.
    input  wire logic        rstn_i,      // Reset, active low.
    input  wire logic        mod_en_i,    // Modulation enable.
    input  wire logic        readout_i,   // Readout strobe.
    input  wire logic        start_i,     // Frame start pulse.
    output logic      [23:0] integ_len_o, // Last integration length.
    output logic      [23:0] read_len_o,  // Last readout length.
    output logic      [7:0]  reads_o      // Readouts in this frame.
);
    logic [23:0] integ_run_ff; // Integration cycles so far.
    logic [23:0] read_run_ff;  // Readout cycles so far.
    // Charge builds only while modulated; the converter takes data only in readout.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            {integ_run_ff, read_run_ff, integ_len_o, read_len_o, reads_o} <= '0;
        end
        else
        begin
            integ_run_ff <= mod_en_i ? integ_run_ff + 24'h000001 : 24'h000000;
            read_run_ff  <= readout_i ? read_run_ff + 24'h000001 : 24'h000000;
            if (!mod_en_i && integ_run_ff != 24'h000000)
                integ_len_o <= integ_run_ff;
            if (!readout_i && read_run_ff != 24'h000000)
                read_len_o <= read_run_ff;
            reads_o <= start_i ? 8'h00 : reads_o + {7'h00, !readout_i && read_run_ff != 24'h000000};
        end
    end
endmodule
`default_nettype wire

//--- tb/test_tof_frame_quad_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_tof_frame_quad_sequencer;
    import tfqs_pkg::*;
    logic clk, rstn, enable, lumped, s_rst, mod_en, readout, active, lowpwr, f_start, f_end;
    logic [7:0] subframes, phase, subframe;
    logic [23:0] integ_cyc, read_cyc, qdead_cyc, pm_integ, pm_read;
    logic [31:0] phases;
    logic [1:0] quad;
    logic [7:0] pm_reads;
    integer seed, errors, checks, cycles, k;
    tfqs_frame_sequencer dut (.CLOCK_I(clk), .RSTN_I(rstn), .ENABLE_I(enable), .LUMPED_DEAD_I(lumped),
        .SUBFRAMES_I(subframes), .INTEG_CYC_I(integ_cyc), .READ_CYC_I(read_cyc), .QDEAD_CYC_I(qdead_cyc),
        .PHASES_I(phases), .SENSOR_RESET_O(s_rst), .MOD_EN_O(mod_en), .PHASE_O(phase), .READOUT_O(readout),
        .SENSOR_ACTIVE_O(active), .ADC_LOWPWR_O(lowpwr), .QUAD_O(quad), .SUBFRAME_O(subframe),
        .FRAME_START_O(f_start), .FRAME_END_O(f_end));
    tfqs_partner_model pm (.clk_i(clk), .rstn_i(rstn), .mod_en_i(mod_en), .readout_i(readout), .start_i(f_start),
        .integ_len_o(pm_integ), .read_len_o(pm_read), .reads_o(pm_reads));
    // Cycles from frame start to the end pulse; zero lengths act as one cycle.
    function automatic int exp_len(input int s, input int i, input int r, input int d, input bit l);
        int se = (s == 0) ? 1 : s;
        int q = TFQS_RESET_CYC + ((i == 0) ? 1 : i) + ((r == 0) ? 1 : r) + (l ? 1 : ((d == 0) ? 1 : d));
        return se * TFQS_QUADS * q + (l ? d * TFQS_QUADS * se : 1);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One frame; enable drops right after the start, which must not cut the frame short.
    task automatic run_frame(input int s, input int i, input int r, input int d, input bit l);
        int n = 0;
        {subframes, integ_cyc, read_cyc, qdead_cyc, lumped} = {s[7:0], i[23:0], r[23:0], d[23:0], l};
        phases = $random(seed);
        enable = 1'b1;
        while (f_start !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            #1 n++;
        end
        enable = 1'b0;
        n = 0;
        while (f_end !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("frame_length", n, exp_len(s, i, r, d, l));
        check("integration_length", {8'h00, pm_integ}, (i == 0) ? 1 : i);
        check("readout_length", {8'h00, pm_read}, (r == 0) ? 1 : r);
        check("readouts", {24'h0, pm_reads}, ((s == 0) ? 1 : s) * TFQS_QUADS);
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk; // Stands in for the external clock source; the sequencer only counts cycles.
    end
    // Hang guard: a stuck frame ends the run as a mismatch.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        {seed, errors, checks, cycles} = {32'h38f0ea90, 96'h0};
        {rstn, enable, lumped, subframes, integ_cyc, read_cyc, qdead_cyc, phases} = '0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        run_frame(0, 0, 0, 0, 1'b0);
        run_frame(2, 5, 3, 7, 1'b1);
        for (k = 0; k < 3; k++)
            run_frame(1 + (($random(seed) >>> 1) & 1), ($random(seed) & 63), 1 + ($random(seed) & 31),
                      1 + ($random(seed) & 31), $random(seed) & 1);
        end_of_test();
    end
endmodule
bind tfqs_frame_sequencer tfqs_props #(.QUADS(QUADS)) u_props (.CLOCK_I, .RSTN_I, .PHASES_I, .SENSOR_RESET_O,
    .MOD_EN_O, .PHASE_O, .READOUT_O, .SENSOR_ACTIVE_O, .ADC_LOWPWR_O, .QUAD_O, .SUBFRAME_O, .FRAME_START_O);
`default_nettype wire
